/* File: hw/tmpf_defines.vh */
// Purpose: Shared constants for the temperature result formatter and pointer block
// Assumes: Raw conversion codes are signed, one sixteenth degree per count
// Notes: Register addresses are pointer values as seen on the two-wire bus
`ifndef TMPF_DEFINES_VH
`define TMPF_DEFINES_VH

`define TMPF_PTR_RST 8'h00
`define TMPF_RD_LOCAL_HI 8'h00
`define TMPF_RD_REMOTE_HI 8'h01
`define TMPF_RD_REMOTE_LO 8'h10
`define TMPF_RD_LOCAL_LO 8'h15
`define TMPF_RD_LTH 8'h05
`define TMPF_RD_LTL 8'h06
`define TMPF_RD_RTH 8'h07
`define TMPF_RD_RTL 8'h08
`define TMPF_WR_LTH 8'h0b
`define TMPF_WR_LTL 8'h0c
`define TMPF_WR_RTH 8'h0d
`define TMPF_WR_RTL 8'h0e
`define TMPF_RES_ADDR 8'h1a
`define TMPF_MFR_ADDR 8'hfe
`define TMPF_DEV_ADDR 8'hff

`define TMPF_LIM_HI_RST 8'h7f
`define TMPF_LIM_LO_RST 8'hc9
`define TMPF_RESULT_RST 8'h00
`define TMPF_RES_FIXED 5'h03
`define TMPF_RC_BIT 2
`define TMPF_RES_HI_BIT 1
`define TMPF_RES_LO_BIT 0
`define TMPF_RES_RST 2'h0
`define TMPF_RES_FINEST 2'h3

`define TMPF_RAW_MAX 16'sh07ff
`define TMPF_RAW_MIN 16'shfbf0
`define TMPF_SAT_HI_HI 8'h7f
`define TMPF_SAT_HI_LO 8'hf0
`define TMPF_SAT_LO_HI 8'hbf
`define TMPF_SAT_LO_LO 8'h00

`endif

/* File: hw/tmpf_fmt.v */
// Purpose: Clamp and encode one raw conversion into high and low result bytes
// Assumes: raw_temp is signed, 1/16 degree per count
// Notes: Purely combinational; the caller registers the bytes
`timescale 1ns/1ps
`include "tmpf_defines.vh"

module tmpf_fmt (
	input wire signed [15:0] raw_temp,
	input wire [1:0] res_sel,
	output reg [7:0] hi_byte,
	output reg [7:0] lo_byte
);
	reg [7:0] lo_mask;

	always @* begin
		case (res_sel)
			2'h0: lo_mask = 8'h80;
			2'h1: lo_mask = 8'hc0;
			2'h2: lo_mask = 8'he0;
			default: lo_mask = 8'hf0;
		endcase
		if (raw_temp > `TMPF_RAW_MAX) begin
			hi_byte = `TMPF_SAT_HI_HI;
			lo_byte = `TMPF_SAT_HI_LO;
		end else if (raw_temp < `TMPF_RAW_MIN) begin
			hi_byte = `TMPF_SAT_LO_HI;
			lo_byte = `TMPF_SAT_LO_LO;
		end else begin
			// Two's complement bits carried straight through
			hi_byte = raw_temp[11:4];
			lo_byte = {raw_temp[3:0], 4'h0} & lo_mask;
		end
	end
endmodule // tmpf_fmt

/* File: hw/tmpf_core.v */
// Purpose: Result formatting, resolution control and register pointer behind the two-wire bus
// Assumes: A bus front end delivers decoded bytes on ref_clk; ADC results arrive on ref_clk
// Notes: Limit compare uses high bytes only; low limit bytes are not held here
//
// Summary of operation
// - Writing the cancel bit as one enables remote series resistance compensation.
// - The cancel bit reads zero after reset, compensation off.
// - Both channels encode results across minus 65 to plus 127.9375 degrees.
// - Results above range saturate to 7F high byte, F0 low byte.
// - Results below minus 65 degrees saturate to BF high, 00 low.
// - Results are signed two's complement values across both bytes.
// - High byte holds whole degrees, low byte holds the fraction.
// - Remote channel resolution is fixed at one sixteenth degree.
// - Local resolution field picks half, quarter, eighth or sixteenth degree.
// - Both local resolution bits set gives the finest twelve-bit result.
// - An eight-bit pointer selects the register for the next access.
// - First data byte of every write transaction loads the pointer.
// - Reset clears the pointer to zero.
// - Results compared with high and low limits drive the open-drain alarm.
`timescale 1ns/1ps
`include "tmpf_defines.vh"

module tmpf_core #(
	parameter [7:0] MFR_ID = 8'ha5,
	parameter [7:0] DEV_ID = 8'h3c
) (
	input wire ref_clk,
	input wire reset,
	input wire clk_en,
	input wire signed [15:0] local_raw,
	input wire local_valid,
	input wire signed [15:0] remote_raw,
	input wire remote_valid,
	input wire xfer_start,
	input wire wr_byte_valid,
	input wire [7:0] wr_byte,
	input wire rd_byte_req,
	output reg [7:0] rd_byte,
	output reg rd_byte_valid,
	output reg alert_o,
	output reg alert_oe,
	output reg series_res_cancel_en,
	output reg [7:0] ptr_out
);
	// MFR_ID and DEV_ID defaults are arbitrary values
	reg [7:0] ptr_reg;
	reg first_byte_reg;
	reg [1:0] local_res_reg;
	reg rc_reg;
	reg [7:0] local_hi_reg;
	reg [7:0] local_lo_reg;
	reg [7:0] remote_hi_reg;
	reg [7:0] remote_lo_reg;
	// Limits hold whole degrees only; fractional limit bytes are not kept
	reg [7:0] lth_reg;
	reg [7:0] ltl_reg;
	reg [7:0] rth_reg;
	reg [7:0] rtl_reg;
	reg snap_valid_reg;
	reg snap_remote_reg;
	reg pair_reg;
	reg [7:0] snap_lo_reg;
	reg [7:0] rd_next;
	reg use_snap;
	wire [7:0] local_hi_fmt;
	wire [7:0] local_lo_fmt;
	wire [7:0] remote_hi_fmt;
	wire [7:0] remote_lo_fmt;
	wire alarm;
	wire local_res_sel_hi;
	wire local_res_sel_lo;
	wire [31:0] raw_bus;
	wire [3:0] res_bus;
	wire [15:0] hi_bus;
	wire [15:0] lo_bus;
	wire [15:0] res_hi_bus;
	wire [15:0] lim_hi_bus;
	wire [15:0] lim_lo_bus;
	wire [1:0] ch_alarm;
	genvar ch;

	assign local_res_sel_hi = local_res_reg[1];
	assign local_res_sel_lo = local_res_reg[0];

	// One formatter and one limit compare per channel; index 0 is local, 1 is remote
	assign raw_bus = {remote_raw, local_raw};
	// Remote resolution is pinned to the finest step; only the local field is live
	assign res_bus = {`TMPF_RES_FINEST, local_res_sel_hi, local_res_sel_lo};
	assign res_hi_bus = {remote_hi_reg, local_hi_reg};
	assign lim_hi_bus = {rth_reg, lth_reg};
	assign lim_lo_bus = {rtl_reg, ltl_reg};

	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
			tmpf_fmt u_fmt (
				.raw_temp(raw_bus[ch * 16 +: 16]),
				.res_sel(res_bus[ch * 2 +: 2]),
				.hi_byte(hi_bus[ch * 8 +: 8]),
				.lo_byte(lo_bus[ch * 8 +: 8])
			);
			// Signed compare on whole degrees; strict, so a result equal to a limit stays quiet
			assign ch_alarm[ch] = ($signed(res_hi_bus[ch * 8 +: 8]) > $signed(lim_hi_bus[ch * 8 +: 8])) |
				($signed(res_hi_bus[ch * 8 +: 8]) < $signed(lim_lo_bus[ch * 8 +: 8]));
		end
	endgenerate

	assign local_hi_fmt = hi_bus[7:0];
	assign local_lo_fmt = lo_bus[7:0];
	assign remote_hi_fmt = hi_bus[15:8];
	assign remote_lo_fmt = lo_bus[15:8];
	assign alarm = |ch_alarm;

	// Low byte snapshot keeps a split read coherent with its high byte
	always @* begin
		use_snap = 1'b0;
		if (snap_valid_reg) begin
			if (pair_reg)
				use_snap = 1'b1;
			else if (ptr_reg == `TMPF_RD_LOCAL_LO && !snap_remote_reg)
				use_snap = 1'b1;
			else if (ptr_reg == `TMPF_RD_REMOTE_LO && snap_remote_reg)
				use_snap = 1'b1;
		end
		case (ptr_reg)
			`TMPF_RD_LOCAL_HI: rd_next = local_hi_reg;
			`TMPF_RD_REMOTE_HI: rd_next = remote_hi_reg;
			`TMPF_RD_LOCAL_LO: rd_next = local_lo_reg;
			`TMPF_RD_REMOTE_LO: rd_next = remote_lo_reg;
			`TMPF_RD_LTH: rd_next = lth_reg;
			`TMPF_RD_LTL: rd_next = ltl_reg;
			`TMPF_RD_RTH: rd_next = rth_reg;
			`TMPF_RD_RTL: rd_next = rtl_reg;
			`TMPF_RES_ADDR: rd_next = {`TMPF_RES_FIXED, rc_reg, local_res_reg};
			`TMPF_MFR_ADDR: rd_next = MFR_ID;
			`TMPF_DEV_ADDR: rd_next = DEV_ID;
			default: rd_next = 8'h00;
		endcase
		if (use_snap)
			rd_next = snap_lo_reg;
	end

	always @(posedge ref_clk) begin
		if (reset) begin
			ptr_reg <= `TMPF_PTR_RST;
			first_byte_reg <= 1'b0;
			local_res_reg <= `TMPF_RES_RST;
			rc_reg <= 1'b0;
			local_hi_reg <= `TMPF_RESULT_RST;
			local_lo_reg <= `TMPF_RESULT_RST;
			remote_hi_reg <= `TMPF_RESULT_RST;
			remote_lo_reg <= `TMPF_RESULT_RST;
			lth_reg <= `TMPF_LIM_HI_RST;
			ltl_reg <= `TMPF_LIM_LO_RST;
			rth_reg <= `TMPF_LIM_HI_RST;
			rtl_reg <= `TMPF_LIM_LO_RST;
			snap_valid_reg <= 1'b0;
			snap_remote_reg <= 1'b0;
			pair_reg <= 1'b0;
			snap_lo_reg <= 8'h00;
			rd_byte <= 8'h00;
			rd_byte_valid <= 1'b0;
			alert_o <= 1'b0;
			alert_oe <= 1'b0;
			series_res_cancel_en <= 1'b0;
			ptr_out <= `TMPF_PTR_RST;
		end else if (clk_en) begin
			if (local_valid) begin
				local_hi_reg <= local_hi_fmt;
				local_lo_reg <= local_lo_fmt;
			end
			if (remote_valid) begin
				remote_hi_reg <= remote_hi_fmt;
				remote_lo_reg <= remote_lo_fmt;
			end
			// Start outranks a byte or a read in the same cycle; the lower request is dropped
			if (xfer_start) begin
				first_byte_reg <= 1'b1;
				pair_reg <= 1'b0;
			end else if (wr_byte_valid) begin
				first_byte_reg <= 1'b0;
				if (first_byte_reg) begin
					ptr_reg <= wr_byte;
				end else begin
					// No autoincrement; read-only and unknown pointers swallow the byte
					case (ptr_reg)
						`TMPF_WR_LTH: lth_reg <= wr_byte;
						`TMPF_WR_LTL: ltl_reg <= wr_byte;
						`TMPF_WR_RTH: rth_reg <= wr_byte;
						`TMPF_WR_RTL: rtl_reg <= wr_byte;
						`TMPF_RES_ADDR: begin
							rc_reg <= wr_byte[`TMPF_RC_BIT];
							local_res_reg <= {wr_byte[`TMPF_RES_HI_BIT], wr_byte[`TMPF_RES_LO_BIT]};
						end
						default: ;
					endcase
				end
			end else if (rd_byte_req) begin
				first_byte_reg <= 1'b0;
				if (!use_snap && (ptr_reg == `TMPF_RD_LOCAL_HI || ptr_reg == `TMPF_RD_REMOTE_HI)) begin
					snap_valid_reg <= 1'b1;
					pair_reg <= 1'b1;
					snap_remote_reg <= (ptr_reg == `TMPF_RD_REMOTE_HI);
					snap_lo_reg <= (ptr_reg == `TMPF_RD_REMOTE_HI) ? remote_lo_reg : local_lo_reg;
				end else begin
					// Any other read drops the snapshot so a stale low byte cannot leak out
					snap_valid_reg <= 1'b0;
					pair_reg <= 1'b0;
				end
			end
			rd_byte_valid <= rd_byte_req & ~xfer_start & ~wr_byte_valid;
			if (rd_byte_req && !xfer_start && !wr_byte_valid)
				rd_byte <= rd_next;
			alert_o <= 1'b0;
			// Pin is only pulled low; release lets the shared wire float high
			alert_oe <= alarm;
			series_res_cancel_en <= rc_reg;
			ptr_out <= ptr_reg;
		end
	end
endmodule // tmpf_core

/* File: test/tmpf_host.sv */
// Purpose: Host model driving the byte-level bus front end of tmpf_core
// Assumes: Requests change at falling edges, sampled at rising edges
// Notes: Released write data shows the inverse of the last byte
`timescale 1ns/1ps
module tmpf_host (
	input wire ref_clk,
	input wire rd_byte_valid,
	input wire [7:0] rd_byte,
	output reg xfer_start = 1'b0,
	output reg wr_byte_valid = 1'b0,
	output reg [7:0] wr_byte = 8'h00,
	output reg rd_byte_req = 1'b0
);
	task st; begin
		@(negedge ref_clk) xfer_start = 1'b1;
		@(negedge ref_clk) xfer_start = 1'b0;
	end endtask
	task wb(input [7:0] b); begin
		@(negedge ref_clk) wr_byte_valid = 1'b1;
		wr_byte = b;
		@(negedge ref_clk) wr_byte_valid = 1'b0;
		wr_byte = ~b;
	end endtask
	// Missing answer turns into unknown so the compare fails
	task rd(output [7:0] d); begin
		@(negedge ref_clk) rd_byte_req = 1'b1;
		@(negedge ref_clk) rd_byte_req = 1'b0;
		d = rd_byte_valid ? rd_byte : 8'hxx;
	end endtask
	task rr(input [7:0] p, output [7:0] d); begin
		st;
		wb(p);
		st;
		rd(d);
	end endtask
	task ww(input [7:0] p, input [7:0] v); begin
		st;
		wb(p);
		wb(v);
	end endtask
endmodule // tmpf_host

/* File: test/tmpf_core_chk.sv */
// Purpose: Port assertions for tmpf_core
// Assumes: bus requests arrive only while clk_en is high
// Notes: Bound to the top module
`timescale 1ns/1ps
module tmpf_core_chk (
	input wire ref_clk,
	input wire reset,
	input wire xfer_start,
	input wire wr_byte_valid,
	input wire [7:0] wr_byte,
	input wire rd_byte_req,
	input wire rd_byte_valid,
	input wire alert_o,
	input wire series_res_cancel_en,
	input wire [7:0] ptr_out
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	reg pend_reg = 1'b0;
	reg [7:0] exp_reg = 8'h00;
	// First byte after a start is the pointer
	always @(posedge ref_clk) begin
		if (reset || xfer_start)
			pend_reg <= !reset;
		else if (wr_byte_valid || rd_byte_req)
			pend_reg <= 1'b0;
		if (wr_byte_valid && pend_reg && !xfer_start)
			exp_reg <= wr_byte;
	end
	property p_rd_ans; rd_byte_req && !xfer_start && !wr_byte_valid |=> rd_byte_valid; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
	property p_rd_cause; rd_byte_valid |-> $past(rd_byte_req); endproperty
	a_rd_cause: assert property (p_rd_cause) else $error("read answer without request");
	property p_rd_pulse; rd_byte_req && !xfer_start && !wr_byte_valid ##1 !rd_byte_req |=> !rd_byte_valid; endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("read answer too long");
	property p_ptr_load; wr_byte_valid && pend_reg && !xfer_start |-> ##[1:2] ptr_out == exp_reg; endproperty
	a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");
	property p_ptr_src; $changed(ptr_out) |-> $past(wr_byte_valid) || $past(wr_byte_valid, 2) || $past(reset); endproperty
	a_ptr_src: assert property (p_ptr_src) else $error("pointer moved alone");
	property p_rc_src; $changed(series_res_cancel_en) |-> $past(wr_byte_valid) || $past(wr_byte_valid, 2) ||
		$past(reset); endproperty
	a_rc_src: assert property (p_rc_src) else $error("cancel moved alone");
	property p_rst; $past(reset) |-> ptr_out == 8'h00 && !series_res_cancel_en && !rd_byte_valid; endproperty
	a_rst: assert property (p_rst) else $error("bad state after reset");
	property p_od; alert_o == 1'b0; endproperty
	a_od: assert property (p_od) else $error("alarm pin driven high");
endmodule // tmpf_core_chk
bind tmpf_core tmpf_core_chk chk_i (.ref_clk, .reset, .xfer_start, .wr_byte_valid, .wr_byte, .rd_byte_req,
	.rd_byte_valid, .alert_o, .series_res_cancel_en, .ptr_out);

/* File: test/tmpf_core_tb.sv */
// Purpose: Self-checking bench for tmpf_core
// Assumes: clk_en high except in the freeze test
// Notes: Rows cover clamps, signs and resolutions
`timescale 1ns/1ps
module tmpf_core_tb;
	reg ref_clk = 1'b0;
	reg reset = 1'b1;
	reg vld = 1'b0;
	reg en = 1'b1;
	reg [15:0] raw = 16'h0000;
	wire xfer_start, wr_byte_valid, rd_byte_req, rd_byte_valid, alert_o, alert_oe, series_res_cancel_en;
	wire [7:0] wr_byte, rd_byte, ptr_out;
	integer fails = 0;
	integer total_checks = 0;
	integer i;
	reg [7:0] h, l;
	reg [47:0] rows [0:5];
	// Identity values are arbitrary and our own, so the reads prove the parameters reach the bus
	tmpf_core #(.MFR_ID(8'h6d), .DEV_ID(8'h92)) dut (.ref_clk, .reset, .clk_en(en), .local_raw(raw),
		.local_valid(vld), .remote_raw(raw),
		.remote_valid(vld), .xfer_start, .wr_byte_valid, .wr_byte, .rd_byte_req, .rd_byte, .rd_byte_valid,
		.alert_o, .alert_oe, .series_res_cancel_en, .ptr_out);
	tmpf_host host (.ref_clk, .rd_byte_valid, .rd_byte, .xfer_start, .wr_byte_valid, .wr_byte, .rd_byte_req);
	task chk(input [7:0] got, input [7:0] exp); begin
		total_checks = total_checks + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("mismatch at %0t: got %h, expected %h", $time, got, exp);
		end
	end endtask
	task complete_run; begin
		$display("checks %0d, fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end endtask
	initial forever #12.5 ref_clk = ~ref_clk;
	initial begin
		#300000;
		fails = fails + 1;
		complete_run;
	end
	initial begin
		// Raw, high, local low, remote low, resolution
		rows[0] = {16'h0800, 8'h7f, 8'hf0, 8'hf0, 8'h03};
		rows[1] = {16'h0004, 8'h00, 8'h40, 8'h40, 8'h01};
		rows[2] = {16'hfffc, 8'hff, 8'h80, 8'hc0, 8'h00};
		rows[3] = {16'hfe70, 8'he7, 8'h00, 8'h00, 8'h02};
		rows[4] = {16'h07ff, 8'h7f, 8'he0, 8'hf0, 8'h02};
		rows[5] = {16'hfb00, 8'hbf, 8'h00, 8'h00, 8'h03};
		repeat (20) @(negedge ref_clk);
		reset = 1'b0;
		host.rr(8'h1a, h);
		chk(h, 8'h18);
		chk(ptr_out, 8'h1a);
		for (i = 0; i < 6; i = i + 1) begin
			host.ww(8'h1a, rows[i][7:0]);
			@(negedge ref_clk) raw = rows[i][47:32];
			vld = 1'b1;
			@(negedge ref_clk) vld = 1'b0;
			host.rr(8'h00, h);
			host.rd(l);
			chk(h, rows[i][31:24]);
			chk(l, rows[i][23:16]);
			host.rr(8'h01, h);
			host.rd(l);
			chk(l, rows[i][15:8]);
			chk(h, rows[i][31:24]);
			$display("row %0d done", i);
		end
		// Last row sits below the default low limit
		chk({7'h00, alert_oe}, 8'h01);
		host.ww(8'h1a, 8'h04);
		repeat (2) @(negedge ref_clk);
		chk({7'h00, series_res_cancel_en}, 8'h01);
		host.rr(8'h40, h);
		chk(h, 8'h00);
		$display("cancel and unmapped done");
		reset = 1'b1;
		@(negedge ref_clk) reset = 1'b0;
		@(negedge ref_clk);
		chk(ptr_out, 8'h00);
		chk({7'h00, series_res_cancel_en}, 8'h00);
		chk({7'h00, alert_oe}, 8'h00);
		$display("reset done");
		// Local low limit above the zero result, then remote high limit below it
		host.ww(8'h0c, 8'h01);
		repeat (2) @(negedge ref_clk);
		chk({7'h00, alert_oe}, 8'h01);
		host.rr(8'h06, h);
		chk(h, 8'h01);
		host.ww(8'h0c, 8'hc9);
		repeat (2) @(negedge ref_clk);
		chk({7'h00, alert_oe}, 8'h00);
		host.ww(8'h0d, 8'hff);
		repeat (2) @(negedge ref_clk);
		chk({7'h00, alert_oe}, 8'h01);
		host.rr(8'h07, h);
		chk(h, 8'hff);
		host.ww(8'h0d, 8'h7f);
		repeat (2) @(negedge ref_clk);
		chk({7'h00, alert_oe}, 8'h00);
		host.rr(8'hfe, h);
		chk(h, 8'h6d);
		host.rr(8'hff, h);
		chk(h, 8'h92);
		$display("limits and identity done");
		// A result strobe while the clock enable is low must be swallowed
		@(negedge ref_clk) en = 1'b0;
		raw = 16'h0190;
		vld = 1'b1;
		@(negedge ref_clk) vld = 1'b0;
		en = 1'b1;
		host.rr(8'h00, h);
		chk(h, 8'h00);
		@(negedge ref_clk) vld = 1'b1;
		@(negedge ref_clk) vld = 1'b0;
		host.rr(8'h00, h);
		chk(h, 8'h19);
		// New fraction lands after the high byte read; the next low byte read keeps the old one
		@(negedge ref_clk) raw = 16'h0198;
		vld = 1'b1;
		@(negedge ref_clk) vld = 1'b0;
		host.rr(8'h15, l);
		chk(l, 8'h00);
		host.rr(8'h15, l);
		chk(l, 8'h80);
		$display("freeze and snapshot done");
		complete_run;
	end
endmodule // tmpf_core_tb
